//--- hdl/iosd_io_space.sv
// Low I/O space decoder with single-bit access and write-one-to-clear flags
`timescale 1ns/100ps
`default_nettype none
module iosd_io_space (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  // Core access port
  input  wire iosd_pkg::iosd_req_t  req,
  output logic                      rsp_valid,
  output logic [7:0]                rsp_rdata,
  output logic                      rsp_skip,
  output logic                      rsp_ext_sel,
  output logic                      rsp_reject,
  // Peripheral side
  input  wire iosd_pkg::iosd_evt_t  evt,
  input  wire logic [7:0]           port_b_pins,
  input  wire logic [7:0]           port_c_pins,
  input  wire logic [7:0]           port_d_pins,
  output logic [7:0]                port_b_out,
  output logic [7:0]                port_b_dir,
  output logic [7:0]                port_c_out,
  output logic [7:0]                port_c_dir,
  output logic [7:0]                port_d_out,
  output logic [7:0]                port_d_dir
);
  import iosd_pkg::*;

  localparam int NREG  = 1 << IO_AW;
  localparam int NFLAG = 6;

  // ==========================================================
  // State
  typedef struct packed {
    logic [NREG-1:0][7:0] regs;
    logic [2:0][7:0]      pin_s1;
    logic [2:0][7:0]      pin_s2;
    iosd_rsp_t            rsp;
  } iosd_st_t;

  iosd_st_t st_q;
  iosd_st_t st_d;

  // ==========================================================
  // Decode helpers
  function automatic logic [7:0] impl_mask(input logic [IO_AW-1:0] a);
    case (a)
      A_PORT_B_PIN, A_PORT_B_DIR, A_PORT_B_OUT,
      A_PORT_D_PIN, A_PORT_D_DIR, A_PORT_D_OUT,
      A_SCRATCH0, A_EE_DATA, A_EE_ADDR_LO, A_EE_ADDR_HI,
      A_TMR0_COUNT, A_TMR0_CMP_A, A_TMR0_CMP_B,
      A_SCRATCH1, A_SCRATCH2, A_SPI_CTRL, A_SPI_DATA: impl_mask = M_FULL;
      A_PORT_C_PIN, A_PORT_C_DIR, A_PORT_C_OUT:       impl_mask = M_PORT_C;
      A_TMR0_FLAGS:  impl_mask = M_TMR0_FLAGS;
      A_TMR1_FLAGS:  impl_mask = M_TMR1_FLAGS;
      A_TMR2_FLAGS:  impl_mask = M_TMR2_FLAGS;
      A_PCHG_FLAGS:  impl_mask = M_PCHG_FLAGS;
      A_EXT_FLAGS:   impl_mask = M_EXT_FLAGS;
      A_EXT_MASK:    impl_mask = M_EXT_MASK;
      A_EE_CTRL:     impl_mask = M_EE_CTRL;
      A_PRESC_SYNC:  impl_mask = M_PRESC_SYNC;
      A_TMR0_CLKSEL: impl_mask = M_TMR0_CLKS;
      A_SPI_STAT:    impl_mask = M_SPI_STAT;
      default:       impl_mask = RESET_VALUE;
    endcase
  endfunction : impl_mask

  // Bits that clear on a written one
  function automatic logic [7:0] w1c_mask(input logic [IO_AW-1:0] a);
    case (a)
      A_TMR0_FLAGS, A_TMR1_FLAGS, A_TMR2_FLAGS,
      A_PCHG_FLAGS, A_EXT_FLAGS: w1c_mask = impl_mask(a);
      A_SPI_STAT:                w1c_mask = W1C_SPI_STAT;
      default:                   w1c_mask = RESET_VALUE;
    endcase
  endfunction : w1c_mask

  function automatic logic read_only(input logic [IO_AW-1:0] a);
    read_only = (a == A_PORT_B_PIN) || (a == A_PORT_C_PIN) || (a == A_PORT_D_PIN);
  endfunction : read_only

  // ==========================================================
  // Flag registers
  logic [NFLAG-1:0][7:0] flag_val;
  logic [NFLAG-1:0][7:0] flag_clr;
  logic [NFLAG-1:0][7:0] flag_set;
  localparam logic [NFLAG-1:0][IO_AW-1:0] FLAG_ADDR =
    {A_SPI_STAT, A_EXT_FLAGS, A_PCHG_FLAGS, A_TMR2_FLAGS, A_TMR1_FLAGS, A_TMR0_FLAGS};
  localparam logic [NFLAG-1:0][7:0] FLAG_MASK =
    {W1C_SPI_STAT, M_EXT_FLAGS, M_PCHG_FLAGS, M_TMR2_FLAGS, M_TMR1_FLAGS, M_TMR0_FLAGS};

  assign flag_set = {evt.spi, evt.ext, evt.pchg, evt.tmr2, evt.tmr1, evt.tmr0};

  genvar gi;
  generate
    for (gi = 0; gi < NFLAG; gi++) begin : g_flag
      iosd_flag_reg #(
        .MASK (FLAG_MASK[gi])
      ) u_flag (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .set_evt  (flag_set[gi]),
        .clr_bits (flag_clr[gi]),
        .flags    (flag_val[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Access logic
  logic               is_io;
  logic [IO_AW-1:0]   io_a;
  logic [7:0]         cur;
  logic [7:0]         bmask;
  logic               wr;
  logic [7:0]         wval;
  logic [7:0]         clr_any;
  logic [IO_AW-1:0]   daddr_io;

  always_comb begin
    st_d      = st_q;
    is_io     = 1'b0;
    io_a      = '0;
    wr        = 1'b0;
    wval      = '0;
    clr_any   = '0;
    cur       = '0;
    daddr_io  = 6'(req.addr - IO_DATA_OFFSET);
    bmask     = 8'h01 << req.bitsel;
    st_d.rsp  = '0;

    // Pin samples pass two flip-flops before anything reads them
    st_d.pin_s1 = {port_d_pins, port_c_pins, port_b_pins};
    st_d.pin_s2 = st_q.pin_s1;

    case (req.cmd)
      IOSD_CMD_PORT_IN, IOSD_CMD_PORT_OUT: begin
        // Upper address bits are outside the 64-entry field
        is_io = (req.addr[DATA_AW-1:IO_AW] == '0);
        io_a  = req.addr[IO_AW-1:0];
      end
      IOSD_CMD_LOAD, IOSD_CMD_STORE: begin
        is_io = (req.addr >= IO_DATA_OFFSET) && (req.addr <= IO_DATA_TOP);
        io_a  = daddr_io;
        st_d.rsp.ext_sel = (req.addr >= EXT_FIRST);
      end
      IOSD_CMD_BIT_SET, IOSD_CMD_BIT_CLR, IOSD_CMD_BIT_TST: begin
        is_io = (req.addr <= {2'b00, BIT_RANGE_TOP});
        io_a  = req.addr[IO_AW-1:0];
      end
      default: begin
        is_io = 1'b0;
      end
    endcase

    // Current visible value; pins read through the synchroniser
    case (io_a)
      A_PORT_B_PIN: cur = st_q.pin_s2[0];
      A_PORT_C_PIN: cur = st_q.pin_s2[1] & M_PORT_C;
      A_PORT_D_PIN: cur = st_q.pin_s2[2];
      default:      cur = st_q.regs[io_a] & impl_mask(io_a);
    endcase
    for (int i = 0; i < NFLAG; i++) begin
      if (io_a == FLAG_ADDR[i]) begin
        cur = (st_q.regs[io_a] & impl_mask(io_a) & ~w1c_mask(io_a)) | flag_val[i];
      end
    end

    if (req.cmd != IOSD_CMD_NONE) begin
      st_d.rsp.valid  = 1'b1;
      st_d.rsp.reject = !is_io && !st_d.rsp.ext_sel;
    end

    if (is_io) begin
      case (req.cmd)
        IOSD_CMD_PORT_IN, IOSD_CMD_LOAD: begin
          st_d.rsp.rdata = cur;
        end
        IOSD_CMD_PORT_OUT, IOSD_CMD_STORE: begin
          wr      = 1'b1;
          wval    = req.wdata;
          clr_any = req.wdata & w1c_mask(io_a);
        end
        IOSD_CMD_BIT_SET: begin
          // Only the named bit changes; a flag bit set clears itself only
          wr      = 1'b1;
          wval    = (st_q.regs[io_a] & ~bmask) | bmask;
          clr_any = bmask & w1c_mask(io_a);
        end
        IOSD_CMD_BIT_CLR: begin
          wr      = 1'b1;
          wval    = st_q.regs[io_a] & ~bmask;
          clr_any = '0;
        end
        IOSD_CMD_BIT_TST: begin
          st_d.rsp.skip = (cur[req.bitsel] == req.skip_on_one);
        end
        default: begin
          wr = 1'b0;
        end
      endcase
    end

    // Reserved addresses and read-only pins ignore writes
    if (wr && !read_only(io_a) && (impl_mask(io_a) != RESET_VALUE)) begin
      st_d.regs[io_a] = wval & impl_mask(io_a) & ~w1c_mask(io_a);
    end
  end

  always_comb begin
    for (int i = 0; i < NFLAG; i++) begin
      flag_clr[i] = (io_a == FLAG_ADDR[i]) ? clr_any : '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs straight from flops
  assign rsp_valid   = st_q.rsp.valid;
  assign rsp_rdata   = st_q.rsp.rdata;
  assign rsp_skip    = st_q.rsp.skip;
  assign rsp_ext_sel = st_q.rsp.ext_sel;
  assign rsp_reject  = st_q.rsp.reject;
  assign port_b_out  = st_q.regs[A_PORT_B_OUT];
  assign port_b_dir  = st_q.regs[A_PORT_B_DIR];
  assign port_c_out  = st_q.regs[A_PORT_C_OUT];
  assign port_c_dir  = st_q.regs[A_PORT_C_DIR];
  assign port_d_out  = st_q.regs[A_PORT_D_OUT];
  assign port_d_dir  = st_q.regs[A_PORT_D_DIR];
endmodule : iosd_io_space
`default_nettype wire

//--- hdl/iosd_pkg.sv
// Package for the low I/O space decoder: addresses, fields, command codes and carriers
package iosd_pkg;

  // ==========================================================
  // Geometry
  localparam int IO_AW   = 6;
  localparam int DATA_AW = 8;
  localparam int BIT_AW  = 3;
  localparam logic [DATA_AW-1:0] IO_DATA_OFFSET = 8'h20;
  localparam logic [DATA_AW-1:0] IO_DATA_TOP    = 8'h5f;
  localparam logic [DATA_AW-1:0] EXT_FIRST      = 8'h60;
  localparam logic [IO_AW-1:0]   BIT_RANGE_TOP  = 6'h1f;

  // ==========================================================
  // Register addresses (I/O space)
  localparam logic [IO_AW-1:0] A_PORT_B_PIN  = 6'h03;
  localparam logic [IO_AW-1:0] A_PORT_B_DIR  = 6'h04;
  localparam logic [IO_AW-1:0] A_PORT_B_OUT  = 6'h05;
  localparam logic [IO_AW-1:0] A_PORT_C_PIN  = 6'h06;
  localparam logic [IO_AW-1:0] A_PORT_C_DIR  = 6'h07;
  localparam logic [IO_AW-1:0] A_PORT_C_OUT  = 6'h08;
  localparam logic [IO_AW-1:0] A_PORT_D_PIN  = 6'h09;
  localparam logic [IO_AW-1:0] A_PORT_D_DIR  = 6'h0a;
  localparam logic [IO_AW-1:0] A_PORT_D_OUT  = 6'h0b;
  localparam logic [IO_AW-1:0] A_TMR0_FLAGS  = 6'h15;
  localparam logic [IO_AW-1:0] A_TMR1_FLAGS  = 6'h16;
  localparam logic [IO_AW-1:0] A_TMR2_FLAGS  = 6'h17;
  localparam logic [IO_AW-1:0] A_PCHG_FLAGS  = 6'h1b;
  localparam logic [IO_AW-1:0] A_EXT_FLAGS   = 6'h1c;
  localparam logic [IO_AW-1:0] A_EXT_MASK    = 6'h1d;
  localparam logic [IO_AW-1:0] A_SCRATCH0    = 6'h1e;
  localparam logic [IO_AW-1:0] A_EE_CTRL     = 6'h1f;
  localparam logic [IO_AW-1:0] A_EE_DATA     = 6'h20;
  localparam logic [IO_AW-1:0] A_EE_ADDR_LO  = 6'h21;
  localparam logic [IO_AW-1:0] A_EE_ADDR_HI  = 6'h22;
  localparam logic [IO_AW-1:0] A_PRESC_SYNC  = 6'h23;
  localparam logic [IO_AW-1:0] A_TMR0_CLKSEL = 6'h25;
  localparam logic [IO_AW-1:0] A_TMR0_COUNT  = 6'h26;
  localparam logic [IO_AW-1:0] A_TMR0_CMP_A  = 6'h27;
  localparam logic [IO_AW-1:0] A_TMR0_CMP_B  = 6'h28;
  localparam logic [IO_AW-1:0] A_SCRATCH1    = 6'h2a;
  localparam logic [IO_AW-1:0] A_SCRATCH2    = 6'h2b;
  localparam logic [IO_AW-1:0] A_SPI_CTRL    = 6'h2c;
  localparam logic [IO_AW-1:0] A_SPI_STAT    = 6'h2d;
  localparam logic [IO_AW-1:0] A_SPI_DATA    = 6'h2e;

  // ==========================================================
  // Implemented-bit masks; other bits are reserved and read zero
  localparam logic [7:0] M_FULL       = 8'hff;
  localparam logic [7:0] M_PORT_C     = 8'h7f;
  localparam logic [7:0] M_TMR0_FLAGS = 8'h07;
  localparam logic [7:0] M_TMR1_FLAGS = 8'h27;
  localparam logic [7:0] M_TMR2_FLAGS = 8'h07;
  localparam logic [7:0] M_PCHG_FLAGS = 8'h07;
  localparam logic [7:0] M_EXT_FLAGS  = 8'h03;
  localparam logic [7:0] M_EXT_MASK   = 8'h03;
  localparam logic [7:0] M_EE_CTRL    = 8'h3f;
  localparam logic [7:0] M_PRESC_SYNC = 8'h83;
  localparam logic [7:0] M_TMR0_CLKS  = 8'hcf;
  localparam logic [7:0] M_SPI_STAT   = 8'hc1;
  // Status flags inside the mixed registers (write one to clear)
  localparam logic [7:0] W1C_SPI_STAT = 8'hc0;
  localparam logic [7:0] RESET_VALUE  = 8'h00;

  // ==========================================================
  // Access commands from the core
  typedef enum logic [2:0] {
    IOSD_CMD_NONE    = 3'h0,
    IOSD_CMD_PORT_IN = 3'h1,  // Port input, 6-bit I/O address
    IOSD_CMD_PORT_OUT= 3'h2,  // Port output, 6-bit I/O address
    IOSD_CMD_LOAD    = 3'h3,  // Direct, indirect or displaced load
    IOSD_CMD_STORE   = 3'h4,  // Direct, indirect or displaced store
    IOSD_CMD_BIT_SET = 3'h5,
    IOSD_CMD_BIT_CLR = 3'h6,
    IOSD_CMD_BIT_TST = 3'h7   // Skip if bit one or zero
  } iosd_cmd_t;

  typedef struct packed {
    iosd_cmd_t              cmd;
    logic [DATA_AW-1:0]     addr;   // I/O address for port/bit ops, data address else
    logic [BIT_AW-1:0]      bitsel;
    logic                   skip_on_one;
    logic [7:0]             wdata;
  } iosd_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
    logic       skip;      // Bit test says skip the next instruction
    logic       ext_sel;   // Extended range strobe for the data bus
    logic       reject;    // Access not served (range or command misuse)
  } iosd_rsp_t;

  // Hardware-set flag events, one bit per flag position
  typedef struct packed {
    logic [7:0] tmr0;
    logic [7:0] tmr1;
    logic [7:0] tmr2;
    logic [7:0] pchg;
    logic [7:0] ext;
    logic [7:0] spi;
  } iosd_evt_t;

endpackage : iosd_pkg

//--- hdl/iosd_flag_reg.sv
// Write-one-to-clear flag register with set-over-clear priority
`timescale 1ns/100ps
`default_nettype none
module iosd_flag_reg #(
  parameter logic [7:0] MASK = 8'hff
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Hardware events and software clear
  input  wire logic [7:0] set_evt,
  input  wire logic [7:0] clr_bits,
  // Stored flags
  output logic [7:0]      flags
);
  import iosd_pkg::*;

  typedef struct packed {
    logic [7:0] flags;
  } iosd_flag_st_t;

  iosd_flag_st_t st_q;
  iosd_flag_st_t st_d;

  always_comb begin
    st_d = st_q;
    // A flag raised in the clearing cycle survives
    st_d.flags = ((st_q.flags & ~clr_bits) | set_evt) & MASK;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign flags = st_q.flags;
endmodule : iosd_flag_reg
`default_nettype wire

//--- tb/iosd_chk.sv
// Checker for the low I/O space decoder ports
`timescale 1ns/100ps
`default_nettype none
module iosd_chk (
  // Clock and reset
  input wire logic                sys_clk,
  input wire logic                rst_b,
  // Core side
  input wire iosd_pkg::iosd_req_t req,
  input wire logic                rsp_valid,
  input wire logic                rsp_ext_sel,
  input wire logic                rsp_reject,
  // Port side
  input wire logic [7:0]          port_b_out,
  input wire logic [7:0]          port_c_out,
  input wire logic [7:0]          port_d_out
);
  import iosd_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================
  // Answer timing and ranges
  req_gets_answer_a: assert property (req.cmd != IOSD_CMD_NONE |=> rsp_valid)
    else $error("no answer after request");
  idle_no_answer_a: assert property (req.cmd == IOSD_CMD_NONE |=> !rsp_valid)
    else $error("answer without request");
  bit_range_a: assert property (req.cmd inside {IOSD_CMD_BIT_SET, IOSD_CMD_BIT_CLR,
    IOSD_CMD_BIT_TST} && req.addr > 8'h1f |=> rsp_reject)
    else $error("bit op above low range served");
  port_range_a: assert property (req.cmd inside {IOSD_CMD_PORT_IN, IOSD_CMD_PORT_OUT}
    && req.addr > 8'h3f |=> rsp_reject)
    else $error("port op beyond 64 locations served");
  ext_by_ls_a: assert property (req.cmd inside {IOSD_CMD_LOAD, IOSD_CMD_STORE}
    && req.addr >= 8'h60 |=> rsp_ext_sel && !rsp_reject)
    else $error("extended access not selected");
  port_no_ext_a: assert property (req.cmd inside {IOSD_CMD_PORT_IN, IOSD_CMD_PORT_OUT}
    |=> !rsp_ext_sel)
    else $error("port op reached extended range");
  // ==========================================
  // Register effects
  store_offset_a: assert property (req.cmd == IOSD_CMD_STORE && req.addr == 8'h25
    |=> port_b_out == $past(req.wdata))
    else $error("store alias missed port b");
  bit_set_one_a: assert property (req.cmd == IOSD_CMD_BIT_SET && req.addr == 8'h0b
    |=> port_d_out == ($past(port_d_out) | (8'h01 << $past(req.bitsel))))
    else $error("bit set touched other bits");
  bit_clr_one_a: assert property (req.cmd == IOSD_CMD_BIT_CLR && req.addr == 8'h0b
    |=> port_d_out == ($past(port_d_out) & ~(8'h01 << $past(req.bitsel))))
    else $error("bit clear touched other bits");
  port_c_top_a: assert property (port_c_out[7] == 1'b0)
    else $error("reserved port c bit set");
endmodule : iosd_chk
bind iosd_io_space iosd_chk iosd_chk_inst (.sys_clk(sys_clk), .rst_b(rst_b), .req(req),
  .rsp_valid(rsp_valid), .rsp_ext_sel(rsp_ext_sel), .rsp_reject(rsp_reject),
  .port_b_out(port_b_out), .port_c_out(port_c_out), .port_d_out(port_d_out));
`default_nettype wire

//--- tb/iosd_core_model.sv
// Processor core model issuing one access per call
`timescale 1ns/100ps
`default_nettype none
module iosd_core_model (
  // Clock
  input  wire logic              sys_clk,
  // Access port
  output var iosd_pkg::iosd_req_t req,
  input  wire logic              rsp_valid,
  input  wire logic [7:0]        rsp_rdata,
  input  wire logic              rsp_skip,
  input  wire logic              rsp_reject,
  input  wire logic              rsp_ext_sel
);
  import iosd_pkg::*;
  logic [7:0] rd;
  logic       vl, sk, rj, ex;
  initial req = '0;
  // Callers pass reserved bits as zero and never write reserved addresses
  task automatic run(input iosd_cmd_t c, input logic [7:0] a, input logic [2:0] b,
                     input logic so, input logic [7:0] wd);
    @(posedge sys_clk);
    req <= '{c, a, b, so, wd};
    @(posedge sys_clk);
    req <= '0;
    #1;
    {vl, rd, sk, rj, ex} = {rsp_valid, rsp_rdata, rsp_skip, rsp_reject, rsp_ext_sel};
  endtask : run
endmodule : iosd_core_model
`default_nettype wire

//--- tb/io_space_decode_bitaccess_tb_top.sv
// Testbench for the low I/O space decoder
`timescale 1ns/100ps
`default_nettype none
module io_space_decode_bitaccess_tb_top;
  import iosd_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst_b   = 1'b0;
  iosd_req_t  req;
  iosd_evt_t  evt     = '0;
  logic [7:0] pbp = 8'hc3, pcp = 8'haa, pdp = 8'h5a;
  logic       rsp_valid, rsp_skip, rsp_ext_sel, rsp_reject;
  logic [7:0] rsp_rdata, pbo, pbd, pco, pcd, pdo, pdd, e;
  int         n_mismatch = 0;
  int         comparisons = 0;
  always #2 sys_clk = ~sys_clk;
  iosd_io_space iosd_io_space_inst (.sys_clk(sys_clk), .rst_b(rst_b), .req(req),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_skip(rsp_skip),
    .rsp_ext_sel(rsp_ext_sel), .rsp_reject(rsp_reject), .evt(evt), .port_b_pins(pbp),
    .port_c_pins(pcp), .port_d_pins(pdp), .port_b_out(pbo), .port_b_dir(pbd),
    .port_c_out(pco), .port_c_dir(pcd), .port_d_out(pdo), .port_d_dir(pdd));
  iosd_core_model iosd_core_model_inst (.sys_clk(sys_clk), .req(req),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_skip(rsp_skip),
    .rsp_reject(rsp_reject), .rsp_ext_sel(rsp_ext_sel));
  // ==========================================
  // Shared tasks
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic acc(input iosd_cmd_t c, input logic [7:0] a, input logic [2:0] b = 3'h0,
                     input logic [7:0] wd = 8'h00, input logic so = 1'b0);
    iosd_core_model_inst.run(c, a, b, so, wd);
  endtask : acc
  task automatic rdp(input logic [7:0] a, input logic [7:0] exp);
    acc(IOSD_CMD_PORT_IN, a);
    chk("read", iosd_core_model_inst.rd, exp);
  endtask : rdp
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  // ==========================================
  // Scenarios
  task automatic t_port;
    rdp(8'h0c, 8'h00);
    acc(IOSD_CMD_PORT_OUT, 8'h05, 3'h0, 8'ha5);
    chk("port_b_out", pbo, 8'ha5);
    acc(IOSD_CMD_LOAD, 8'h25);
    chk("load alias", iosd_core_model_inst.rd, 8'ha5);
    acc(IOSD_CMD_STORE, 8'h3e, 3'h0, 8'h3c);
    rdp(8'h1e, 8'h3c);
    acc(IOSD_CMD_PORT_IN, 8'h3f);
    chk("top port addr", iosd_core_model_inst.rj, 8'h00);
    acc(IOSD_CMD_PORT_IN, 8'h40);
    chk("beyond port addr", iosd_core_model_inst.rj, 8'h01);
    acc(IOSD_CMD_PORT_OUT, 8'h07, 3'h0, 8'h55);
    chk("port_c_dir", pcd, 8'h55);
    rdp(8'h06, 8'h2a);
    $display("t_port done");
  endtask : t_port
  task automatic t_bits;
    acc(IOSD_CMD_PORT_OUT, 8'h0b, 3'h0, 8'h81);
    e = 8'h81;
    for (int i = 0; i < 8; i++) begin
      acc(IOSD_CMD_BIT_SET, 8'h0b, 3'(i));
      e[i] = 1'b1;
      chk("bit set", pdo, e);
    end
    for (int i = 0; i < 8; i += 2) begin
      acc(IOSD_CMD_BIT_CLR, 8'h0b, 3'(i));
      e[i] = 1'b0;
      chk("bit clear", pdo, e);
    end
    for (int i = 0; i < 8; i++) begin
      acc(IOSD_CMD_BIT_TST, 8'h09, 3'(i), 8'h00, 1'b1);
      chk("skip on one", iosd_core_model_inst.sk, 8'(pdp[i]));
      acc(IOSD_CMD_BIT_TST, 8'h09, 3'(i), 8'h00, 1'b0);
      chk("skip on zero", iosd_core_model_inst.sk, 8'(!pdp[i]));
    end
    acc(IOSD_CMD_PORT_OUT, 8'h20, 3'h0, 8'h11);
    acc(IOSD_CMD_BIT_SET, 8'h20, 3'h7);
    chk("bit op high", iosd_core_model_inst.rj, 8'h01);
    rdp(8'h20, 8'h11);
    $display("t_bits done");
  endtask : t_bits
  task automatic t_flags;
    @(posedge sys_clk);
    evt <= '{tmr0: 8'hff, ext: 8'h03, spi: 8'hc0, default: 8'h00};
    @(posedge sys_clk);
    evt <= '0;
    rdp(8'h15, 8'h07);
    acc(IOSD_CMD_PORT_OUT, 8'h15, 3'h0, 8'h00);
    rdp(8'h15, 8'h07);
    acc(IOSD_CMD_PORT_OUT, 8'h15, 3'h0, 8'h01);
    rdp(8'h15, 8'h06);
    acc(IOSD_CMD_BIT_SET, 8'h15, 3'h1);
    rdp(8'h15, 8'h04);
    acc(IOSD_CMD_BIT_CLR, 8'h15, 3'h2);
    rdp(8'h15, 8'h04);
    acc(IOSD_CMD_PORT_OUT, 8'h1c, 3'h0, 8'h02);
    rdp(8'h1c, 8'h01);
    acc(IOSD_CMD_STORE, 8'h4d, 3'h0, 8'h40);
    acc(IOSD_CMD_LOAD, 8'h4d);
    chk("spi flags", iosd_core_model_inst.rd, 8'h80);
    // Clearing write and hardware set taken at the same edge: set must win
    fork
      acc(IOSD_CMD_PORT_OUT, 8'h17, 3'h0, 8'h01);
      begin
        @(posedge sys_clk);
        evt <= '{tmr2: 8'h01, default: 8'h00};
        @(posedge sys_clk);
        evt <= '0;
      end
    join
    rdp(8'h17, 8'h01);
    $display("t_flags done");
  endtask : t_flags
  task automatic t_reset;
    rdp(8'h03, 8'hc3);
    acc(IOSD_CMD_PORT_OUT, 8'h04, 3'h0, 8'h3c);
    chk("answer", iosd_core_model_inst.vl, 8'h01);
    chk("port_b_dir", pbd, 8'h3c);
    acc(IOSD_CMD_STORE, 8'h28, 3'h0, 8'h7f);
    chk("port_c_out", pco, 8'h7f);
    acc(IOSD_CMD_BIT_SET, 8'h0a, 3'h6);
    chk("port_d_dir", pdd, 8'h40);
    @(posedge sys_clk);
    evt <= '{tmr1: 8'hff, pchg: 8'hff, default: 8'h00};
    @(posedge sys_clk);
    evt <= '0;
    rdp(8'h16, 8'h27);
    rdp(8'h1b, 8'h07);
    // Reset in mid-run clears storage, flags and the answer
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1;
    chk("reset b dir", pbd, 8'h00);
    chk("reset c out", pco, 8'h00);
    chk("reset d dir", pdd, 8'h00);
    chk("reset answer", rsp_valid, 8'h00);
    rdp(8'h16, 8'h00);
    rdp(8'h1b, 8'h00);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_ext;
    acc(IOSD_CMD_LOAD, 8'h60);
    chk("ext low", iosd_core_model_inst.ex, 8'h01);
    acc(IOSD_CMD_STORE, 8'hff, 3'h0, 8'h00);
    chk("ext high", iosd_core_model_inst.ex, 8'h01);
    acc(IOSD_CMD_LOAD, 8'h1f);
    chk("load below io", iosd_core_model_inst.rj, 8'h01);
    $display("t_ext done");
  endtask : t_ext
  // ==========================================
  // Sequence and watchdog
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_port();
    t_bits();
    t_flags();
    t_ext();
    t_reset();
    summarize();
  end
  initial begin
    #20000;
    n_mismatch++;
    summarize();
  end
endmodule : io_space_decode_bitaccess_tb_top
`default_nettype wire
